// ==== dv/dpr_power_removal_tb_top.sv ====
// self-checking bench of the power removal controller
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dpr_power_removal_tb_top;
  import dpr_pkg::*;
  localparam int FLT = 8;
  localparam int RSP = 40;
  localparam int BLK = 4;
  // a, b, edm, ready, upper, lower, monitor
  localparam logic [6:0] ROWS [4] = '{7'b1101110, 7'b0010001, 7'b1000100, 7'b0100010};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [WB_AW-1:0] adr = '0;
  logic [31:0] wdat = '0;
  logic [3:0] sel = '0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic [31:0] rdat, q;
  logic ack, ext_device_monitor_out, mon, rdy, prdy, brk, led, up, lo, mot, cha, chb, clr, l0;
  int miscompares = 0;
  int n_checks = 0;
  always #12.5 clk = ~clk;
  dpr_power_removal #(.FILT_CYC(FLT), .RESP_CYC(RSP), .BLINK_CYC(BLK)) i_dpr_power_removal (
    .clk_i(clk), .rst_i(rst), .adr_i(adr), .dat_i(wdat), .sel_i(sel), .we_i(we),
    .cyc_i(cyc), .stb_i(stb), .dat_o(rdat), .ack_o(ack),
    .safety_channel_a_i(cha), .safety_channel_b_i(chb), .safe_off_clear_in_i(clr),
    .ext_device_monitor_out_o(ext_device_monitor_out), .safe_off_monitor_out_o(mon), .ready_o(rdy),
    .pulse_input_ready_out_o(prdy), .brake_control_out_o(brk),
    .power_alarm_indicator_o(led), .upper_gate_en_o(up), .lower_gate_en_o(lo),
    .motor_excited_o(mot));
  dpr_safety_model #(.HOLD_CYC(RSP), .GLITCH_MAX(FLT / 2)) i_dpr_safety_model (
    .clk_i(clk), .edm_i(ext_device_monitor_out), .chan_a_o(cha), .chan_b_o(chb), .clr_o(clr));
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    if (ack !== 1'b1) miscompares++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  initial begin
    repeat (6) @(posedge clk);
    `CHK({rdy, up, ext_device_monitor_out}, 3'b000)
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK({rdy, mot, ext_device_monitor_out, led}, 4'b1101)
    for (int i = 0; i < 4; i++) begin
      i_dpr_safety_model.drive(ROWS[i][6], ROWS[i][5]);
      `CHK({ext_device_monitor_out, rdy, up, lo, mon}, ROWS[i][4:0])
      `CHK({prdy, brk, mot}, {ROWS[i][3], ROWS[i][3], ROWS[i][2] & ROWS[i][1]})
      i_dpr_safety_model.release_both();
      `CHK({rdy, mot}, {2{ROWS[i] != 7'b0010001}})
      i_dpr_safety_model.clear();
      `CHK({rdy, prdy, brk, mot, mon, led}, 6'b111101)
    end
    wb(1'b0, ADR_CTRL, 32'h0, 4'hf);
    `CHK(q[CTRL_W-1:0], CTRL_RST)
    wb(1'b1, ADR_CTRL, 32'h1, 4'he);
    wb(1'b1, 4'h8, 32'h3, 4'hf);
    wb(1'b0, ADR_CTRL, 32'h0, 4'hf);
    `CHK(q, 32'h0)
    wb(1'b0, 4'h8, 32'h0, 4'hf);
    `CHK(q, 32'h0)
    wb(1'b1, ADR_STATUS, 32'hff, 4'hf);
    wb(1'b0, ADR_STATUS, 32'h0, 4'hf);
    `CHK(q[6:0], 7'h13)
    wb(1'b1, ADR_CTRL, 32'h1, 4'h1);
    wb(1'b0, ADR_CTRL, 32'h0, 4'hf);
    `CHK(q, 32'h1)
    i_dpr_safety_model.drive(1'b0, 1'b0);
    `CHK({mon, ext_device_monitor_out, rdy, brk}, 4'b0100)
    l0 = led;
    repeat (BLK) @(posedge clk);
    `CHK(led, ~l0)
    i_dpr_safety_model.drive(1'b1, 1'b0);
    i_dpr_safety_model.clear();
    wb(1'b0, ADR_STATUS, 32'h0, 4'hf);
    `CHK({q[6:0], rdy, mot}, {7'h05, 2'b00})
    // clear held high over release: edge mode must not take it
    i_dpr_safety_model.set_clear(1'b1);
    i_dpr_safety_model.release_both();
    `CHK({rdy, mot}, 2'b00)
    wb(1'b1, ADR_CTRL, 32'h2, 4'h1);
    repeat (8) @(posedge clk);
    `CHK({rdy, mon, led}, 3'b101)
    i_dpr_safety_model.set_clear(1'b0);
    for (int k = 0; k < 2; k++) begin
      fork
        i_dpr_safety_model.glitch(k[0], FLT / 2);
        repeat (RSP) begin
          @(posedge clk);
          `CHK({rdy, mot, ext_device_monitor_out, led}, 4'b1101)
        end
      join
    end
    `CHK(i_dpr_safety_model.fault, 1'b0)
    summarize();
  end
  // generous bound over the roughly 640 cycles the sequence needs
  initial begin
    repeat (6000) @(posedge clk);
    miscompares++;
    summarize();
  end
endmodule : dpr_power_removal_tb_top

// ==== dv/dpr_safety_model.sv ====
// behavioural external safety controller driving both channels and clear
`timescale 1ns/10ps
module dpr_safety_model #(
  parameter int HOLD_CYC = 40,
  parameter int GLITCH_MAX = 4
) (
  // clock
  input wire logic clk_i,
  // monitor from the block
  input wire logic edm_i,
  // pins, high = ON
  output logic chan_a_o,
  output logic chan_b_o,
  output logic clr_o
);
  logic fault;
  initial begin
    chan_a_o = 1'b1;
    chan_b_o = 1'b1;
    clr_o = 1'b0;
    fault = 1'b0;
  end
  task automatic drive(input logic a, input logic b);
    @(posedge clk_i);
    chan_a_o <= a;
    chan_b_o <= b;
    repeat (HOLD_CYC) @(posedge clk_i);
  endtask : drive
  task automatic glitch(input logic on_a, input int n);
    @(posedge clk_i);
    if (on_a) begin
      chan_a_o <= 1'b0;
    end else begin
      chan_b_o <= 1'b0;
    end
    repeat ((n > GLITCH_MAX) ? GLITCH_MAX : n) @(posedge clk_i);
    chan_a_o <= 1'b1;
    chan_b_o <= 1'b1;
  endtask : glitch
  task automatic release_both();
    if (!chan_a_o && !chan_b_o && edm_i !== 1'b1) begin
      fault = 1'b1;
    end else begin
      drive(1'b1, 1'b1);
    end
  endtask : release_both
  task automatic set_clear(input logic v);
    @(posedge clk_i);
    clr_o <= v;
  endtask : set_clear
  task automatic clear();
    set_clear(1'b1);
    repeat (4) @(posedge clk_i);
    set_clear(1'b0);
    repeat (4) @(posedge clk_i);
  endtask : clear
endmodule : dpr_safety_model

// ==== src/dpr_chan_filter.sv ====
// synchronisers for the two safety channels and clear, pulse filters for the channels only
`timescale 1ns/10ps
module dpr_chan_filter
  import dpr_pkg::*;
#(
  parameter int FILT_CYC = FILT_CYC_DEF
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // raw pins, high = ON
  input wire logic safety_channel_a_i,
  input wire logic safety_channel_b_i,
  input wire logic safe_off_clear_in_i,
  // conditioned signals
  dpr_chan_if.filt ch
);
  // pulse rejection at the real clock rests on the default; short benches scale it down
  if (FILT_CYC < 2 || FILT_CYC >= (1 << CNT_W)) begin : g_bad_filt
    $error("FILT_CYC out of range");
  end

  typedef struct packed {
    logic a_m;
    logic a_s;
    logic b_m;
    logic b_s;
    logic c_m;
    logic c_s;
    logic a_on;
    logic b_on;
    logic [CNT_W-1:0] a_cnt;
    logic [CNT_W-1:0] b_cnt;
  } dpr_filt_s;

  dpr_filt_s filt_reg;
  dpr_filt_s filt_next;

  // new level is taken only after it held FILT_CYC cycles
  function automatic logic [CNT_W:0] dpr_step(input logic lvl, input logic on,
                                             input logic [CNT_W-1:0] cnt);
    logic [CNT_W:0] res;
    res = {on, {CNT_W{1'b0}}};
    if (lvl != on) begin
      if (cnt == CNT_W'(FILT_CYC - 1)) begin
        res = {lvl, {CNT_W{1'b0}}};
      end else begin
        res = {on, cnt + 1'b1};
      end
    end
    return res;
  endfunction : dpr_step

  always_comb begin
    filt_next = filt_reg;
    // R20 two-stage synchronisers
    filt_next.a_m = safety_channel_a_i;
    filt_next.a_s = filt_reg.a_m;
    filt_next.b_m = safety_channel_b_i;
    filt_next.b_s = filt_reg.b_m;
    filt_next.c_m = safe_off_clear_in_i;
    filt_next.c_s = filt_reg.c_m;
    // R8 short OFF pulses dropped
    {filt_next.a_on, filt_next.a_cnt} = dpr_step(filt_reg.a_s, filt_reg.a_on, filt_reg.a_cnt);
    {filt_next.b_on, filt_next.b_cnt} = dpr_step(filt_reg.b_s, filt_reg.b_on, filt_reg.b_cnt);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_reg <= '0;
      filt_reg.a_m <= 1'b1;
      filt_reg.a_s <= 1'b1;
      filt_reg.b_m <= 1'b1;
      filt_reg.b_s <= 1'b1;
      filt_reg.a_on <= 1'b1;
      filt_reg.b_on <= 1'b1;
    end else begin
      filt_reg <= filt_next;
    end
  end

  assign ch.a_sync = filt_reg.a_s;
  assign ch.b_sync = filt_reg.b_s;
  assign ch.a_on = filt_reg.a_on;
  assign ch.b_on = filt_reg.b_on;
  assign ch.clr_sync = filt_reg.c_s;

  AST_GLITCH_HELD: assert property (@(posedge clk_i) disable iff (rst_i) // R8
    (filt_reg.a_on && !filt_reg.a_s && filt_reg.a_cnt == '0) |=> filt_reg.a_on)
    else $error("channel A OFF taken without filtering");
endmodule : dpr_chan_filter

// ==== src/dpr_chan_if.sv ====
// carrier of conditioned channel and clear signals
`timescale 1ns/10ps
interface dpr_chan_if;
  logic a_sync;
  logic b_sync;
  logic a_on;
  logic b_on;
  logic clr_sync;
  modport filt (output a_sync, output b_sync, output a_on, output b_on, output clr_sync);
  modport ctl (input a_sync, input b_sync, input a_on, input b_on, input clr_sync);
endinterface : dpr_chan_if

// ==== src/dpr_pkg.sv ====
// shared constants and types of the dual channel power removal block
// Contract
// R1: both channels OFF enters power removal and cuts motor drive.
// R2: in power removal with alarm mode off, safe-off monitor output is ON.
// R3: in power removal, ready, pulse-input-ready and brake-control outputs are OFF.
// R4: in power removal, power/alarm indicator blinks green.
// R5: in power removal, brake stays engaged holding the shaft.
// R6: power removal entered within 15 ms after both channels go OFF.
// R7: safety device holds both channels OFF at least 15 ms to request removal.
// R8: OFF pulses of 1 ms or less are ignored; partner keeps them that short.
// R9: both channels back ON leaves removal, motor stays off until clear.
// R10: by default a rising edge on the clear input requests re-excitation.
// R11: on clear, monitor output OFF; ready, pulse-ready and brake-control ON.
// R12: after re-excitation indicator is steady green and brake released.
// R13: removal is not released while only one channel is back ON.
// R14: partner keeps both channels ON at least 15 ms to release.
// R15: device monitor output ON only when both channels are OFF.
// R16: one channel OFF keeps device monitor OFF and motor non-excited.
// R17: partner must not release while device monitor is OFF; flags failure.
// R18: channel A OFF blocks upper gates, channel B OFF blocks lower gates.
// R19: power-up with both channels ON excites motor, device monitor OFF.
// R20: channels and clear input are synchronised before any use.
package dpr_pkg;
  localparam longint CLK_HZ = 40_000_000;
  localparam longint US_PER_S = 1_000_000;
  localparam longint MS_PER_S = 1_000;
  // longest ignored OFF pulse, and the qualifying filter time above it
  localparam int GLITCH_US = 1000;
  localparam int FILT_US = 2000;
  localparam int RESP_MS = 15;
  localparam int BLINK_MS = 250;
  localparam int CNT_W = 24;
  localparam int GLITCH_CYC = int'((longint'(GLITCH_US) * CLK_HZ) / US_PER_S);
  localparam int FILT_CYC_DEF = int'((longint'(FILT_US) * CLK_HZ + US_PER_S - 1) / US_PER_S);
  localparam int RESP_CYC_DEF = int'((longint'(RESP_MS) * CLK_HZ) / MS_PER_S);
  localparam int BLINK_CYC_DEF = int'((longint'(BLINK_MS) * CLK_HZ) / MS_PER_S);
  // wishbone map
  localparam int WB_AW = 4;
  localparam logic [WB_AW-1:0] ADR_CTRL = 4'h0;
  localparam logic [WB_AW-1:0] ADR_STATUS = 4'h4;
  localparam int CTRL_W = 2;
  localparam int CTRL_ALARM_BIT = 0;
  localparam int CTRL_CLR_LEVEL_BIT = 1;
  localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;
  localparam int ST_A_ON_BIT = 0;
  localparam int ST_B_ON_BIT = 1;
  localparam int ST_REMOVED_BIT = 2;
  localparam int ST_WAIT_BIT = 3;
  localparam int ST_RUN_BIT = 4;
  localparam int ST_EDM_BIT = 5;
  localparam int ST_MON_BIT = 6;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_REMOVED = 3'b010,
    ST_WAIT_CLR = 3'b100
  } dpr_state_e;
endpackage : dpr_pkg

// ==== src/dpr_power_removal.sv ====
// dual channel power removal controller with wishbone registers
`timescale 1ns/10ps
module dpr_power_removal
  import dpr_pkg::*;
#(
  parameter int FILT_CYC = FILT_CYC_DEF,
  parameter int RESP_CYC = RESP_CYC_DEF,
  parameter int BLINK_CYC = BLINK_CYC_DEF
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic [WB_AW-1:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // safety pins, high = ON
  input wire logic safety_channel_a_i,
  input wire logic safety_channel_b_i,
  input wire logic safe_off_clear_in_i,
  // status and drive outputs
  output logic ext_device_monitor_out_o,
  output logic safe_off_monitor_out_o,
  output logic ready_o,
  output logic pulse_input_ready_out_o,
  output logic brake_control_out_o,
  output logic power_alarm_indicator_o,
  output logic upper_gate_en_o,
  output logic lower_gate_en_o,
  output logic motor_excited_o
);
  if (RESP_CYC <= FILT_CYC + 4 || RESP_CYC >= (1 << CNT_W)) begin : g_bad_resp
    $error("RESP_CYC cannot be met by the filter");
  end
  if (BLINK_CYC < 2 || BLINK_CYC >= (1 << CNT_W)) begin : g_bad_blink
    $error("BLINK_CYC out of range");
  end

  typedef struct packed {
    dpr_state_e st;
    logic [CTRL_W-1:0] ctrl;
    logic ack;
    logic [31:0] rdat;
    logic clr_prev;
    logic [CNT_W-1:0] blink_cnt;
    logic blink;
    logic [CNT_W-1:0] resp_cnt;
    logic mon;
    logic ext_device_monitor_out;
    logic rdy;
    logic brk;
    logic led;
    logic gate_u;
    logic gate_l;
  } dpr_top_s;

  dpr_top_s top_reg;
  dpr_top_s top_next;
  logic both_off;
  logic both_on;
  logic one_off;
  logic clr_req;
  logic wb_req;
  logic [31:0] status_word;

  dpr_chan_if ch ();

  dpr_chan_filter #(
    .FILT_CYC(FILT_CYC)
  ) u_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .safety_channel_a_i(safety_channel_a_i),
    .safety_channel_b_i(safety_channel_b_i),
    .safe_off_clear_in_i(safe_off_clear_in_i),
    .ch(ch.filt)
  );

  always_comb begin
    both_off = !ch.a_on && !ch.b_on;
    both_on = ch.a_on && ch.b_on;
    one_off = ch.a_on ^ ch.b_on;
    // R10 edge by default, level when selected
    if (top_reg.ctrl[CTRL_CLR_LEVEL_BIT]) begin
      clr_req = ch.clr_sync;
    end else begin
      clr_req = ch.clr_sync && !top_reg.clr_prev;
    end
    wb_req = cyc_i && stb_i && !top_reg.ack;
    status_word = '0;
    status_word[ST_A_ON_BIT] = ch.a_on;
    status_word[ST_B_ON_BIT] = ch.b_on;
    status_word[ST_REMOVED_BIT] = top_reg.st == ST_REMOVED;
    status_word[ST_WAIT_BIT] = top_reg.st == ST_WAIT_CLR;
    status_word[ST_RUN_BIT] = top_reg.st == ST_RUN;
    status_word[ST_EDM_BIT] = top_reg.ext_device_monitor_out;
    status_word[ST_MON_BIT] = top_reg.mon;
  end

  always_comb begin
    top_next = top_reg;
    top_next.clr_prev = ch.clr_sync;
    unique case (top_reg.st)
      ST_RUN: begin
        // R1 both OFF enters removal
        if (both_off) begin
          top_next.st = ST_REMOVED;
        end
      end
      ST_REMOVED: begin
        // R13 one channel alone never releases
        if (both_on) begin
          top_next.st = ST_WAIT_CLR;
        end
      end
      ST_WAIT_CLR: begin
        // R9 stays non-excited until clear
        if (both_off) begin
          top_next.st = ST_REMOVED;
        end else if (both_on && clr_req) begin
          top_next.st = ST_RUN;
        end
      end
      default: begin
        // corrupted code falls to the safe state
        top_next.st = ST_REMOVED;
      end
    endcase

    // R3 outputs only in run with both ON
    // R11 ready group back on after clear
    top_next.rdy = top_reg.st == ST_RUN && both_on;
    // R5 brake held unless running
    // R12 brake released once running
    top_next.brk = top_reg.st == ST_RUN && both_on;
    // R18 each channel blocks its own arm
    // R16 one channel OFF cuts its arm
    top_next.gate_u = top_reg.st == ST_RUN && ch.a_on;
    top_next.gate_l = top_reg.st == ST_RUN && ch.b_on;
    // R2 monitor only without alarm mode
    top_next.mon = top_reg.st != ST_RUN && !top_reg.ctrl[CTRL_ALARM_BIT];
    // R15 device monitor on both OFF only
    top_next.ext_device_monitor_out = both_off;

    // R4 blink while not running
    if (top_reg.blink_cnt == CNT_W'(BLINK_CYC - 1)) begin
      top_next.blink_cnt = '0;
      top_next.blink = !top_reg.blink;
    end else begin
      top_next.blink_cnt = top_reg.blink_cnt + 1'b1;
    end
    // R12 steady green in run
    top_next.led = (top_reg.st == ST_RUN) ? 1'b1 : top_reg.blink;

    // R6 response-time watch on synchronised pins
    if (!ch.a_sync && !ch.b_sync) begin
      if (top_reg.resp_cnt != CNT_W'(RESP_CYC)) begin
        top_next.resp_cnt = top_reg.resp_cnt + 1'b1;
      end
    end else begin
      top_next.resp_cnt = '0;
    end

    // one wait state; write lands on the ack edge
    top_next.ack = wb_req;
    if (wb_req) begin
      unique case (adr_i)
        ADR_CTRL: top_next.rdat = {{(32-CTRL_W){1'b0}}, top_reg.ctrl};
        ADR_STATUS: top_next.rdat = status_word;
        default: top_next.rdat = '0;
      endcase
    end
    if (top_reg.ack && cyc_i && stb_i && we_i && adr_i == ADR_CTRL && sel_i[0]) begin
      top_next.ctrl = dat_i[CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      top_reg <= '0;
      // R19 start excited; filter starts at both ON
      top_reg.st <= ST_RUN;
      top_reg.ctrl <= CTRL_RST;
    end else begin
      top_reg <= top_next;
    end
  end

  assign dat_o = top_reg.rdat;
  assign ack_o = top_reg.ack;
  assign ext_device_monitor_out_o = top_reg.ext_device_monitor_out;
  assign safe_off_monitor_out_o = top_reg.mon;
  assign ready_o = top_reg.rdy;
  assign pulse_input_ready_out_o = top_reg.rdy;
  assign brake_control_out_o = top_reg.brk;
  assign power_alarm_indicator_o = top_reg.led;
  assign upper_gate_en_o = top_reg.gate_u;
  assign lower_gate_en_o = top_reg.gate_l;
  assign motor_excited_o = top_reg.gate_u && top_reg.gate_l;

  AST_ENTER_REMOVAL: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    both_off |-> ##2 (!upper_gate_en_o && !lower_gate_en_o && !motor_excited_o))
    else $error("drive not cut after both channels OFF");

  AST_MON_ON: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    (top_reg.st == ST_REMOVED && !top_reg.ctrl[CTRL_ALARM_BIT]) |=> safe_off_monitor_out_o)
    else $error("safe-off monitor not ON in removal");

  AST_READY_OFF: assert property (@(posedge clk_i) disable iff (rst_i) // R3
    (top_reg.st != ST_RUN) |=> (!ready_o && !pulse_input_ready_out_o))
    else $error("ready outputs ON outside run");

  AST_BLINK: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    // entry cycle skipped: the indicator still shows the run level there
    (top_reg.st == ST_REMOVED && $past(top_reg.st) == ST_REMOVED && $changed(top_reg.blink))
    |=> $changed(power_alarm_indicator_o))
    else $error("indicator not following blink");

  AST_BRAKE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    (top_reg.st != ST_RUN) |=> !brake_control_out_o)
    else $error("brake released outside run");

  AST_RESP_TIME: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    (top_reg.resp_cnt == CNT_W'(RESP_CYC)) |-> (top_reg.st != ST_RUN && !motor_excited_o))
    else $error("removal not entered within response time");

  AST_WAIT_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i) // R9
    (top_reg.st == ST_REMOVED && both_on) |=> (top_reg.st == ST_WAIT_CLR) ##1 !ready_o)
    else $error("release did not wait for clear");

  AST_CLR_EDGE: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    (top_reg.st == ST_WAIT_CLR && both_on && !top_reg.ctrl[CTRL_CLR_LEVEL_BIT]
     && ch.clr_sync && !$past(ch.clr_sync)) |=> (top_reg.st == ST_RUN))
    else $error("clear edge not honoured");

  AST_REEXCITE: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    ($rose(top_reg.st == ST_RUN) && both_on) |=> (ready_o && brake_control_out_o
                                                   && !safe_off_monitor_out_o))
    else $error("outputs wrong after re-excitation");

  AST_STEADY_LED: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    (top_reg.st == ST_RUN) [*2] |=> power_alarm_indicator_o)
    else $error("indicator not steady in run");

  AST_ONE_CHANNEL: assert property (@(posedge clk_i) disable iff (rst_i) // R13
    (top_reg.st == ST_REMOVED && one_off) |=> (top_reg.st == ST_REMOVED))
    else $error("removal released by one channel");

  AST_EDM_BOTH: assert property (@(posedge clk_i) disable iff (rst_i) // R15
    ext_device_monitor_out_o |-> $past(both_off))
    else $error("device monitor ON without both OFF");

  AST_EDM_ONE: assert property (@(posedge clk_i) disable iff (rst_i) // R16
    one_off |=> (!ext_device_monitor_out_o && !motor_excited_o))
    else $error("one channel OFF mishandled");

  AST_GATE_SPLIT: assert property (@(posedge clk_i) disable iff (rst_i) // R18
    (!ch.a_on |=> !upper_gate_en_o) and (!ch.b_on |=> !lower_gate_en_o))
    else $error("arm gate not blocked by its channel");

  AST_PWRUP: assert property (@(posedge clk_i) disable iff (rst_i) // R19
    $fell(rst_i) |-> (top_reg.st == ST_RUN && !ext_device_monitor_out_o))
    else $error("not excited at power-up");

  AST_GATES_BACK: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    ($rose(top_reg.st == ST_RUN) && both_on)
    |=> (upper_gate_en_o && lower_gate_en_o && pulse_input_ready_out_o))
    else $error("drive not restored after clear");

  AST_MON_OFF_RUN: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    (top_reg.st == ST_RUN) |=> !safe_off_monitor_out_o)
    else $error("safe-off monitor ON in run");

  AST_BRAKE_FREE: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    (top_reg.st == ST_RUN && both_on) |=> brake_control_out_o)
    else $error("brake not released in run");

  AST_ALARM_QUIET: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    top_reg.ctrl[CTRL_ALARM_BIT] |=> !safe_off_monitor_out_o)
    else $error("safe-off monitor ON in alarm mode");

  AST_EDM_SET: assert property (@(posedge clk_i) disable iff (rst_i) // R15
    both_off |=> ext_device_monitor_out_o)
    else $error("device monitor OFF with both channels OFF");

  AST_GATE_RUN: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    (top_reg.st != ST_RUN) |=> (!upper_gate_en_o && !lower_gate_en_o))
    else $error("gate drive ON outside run");

  AST_REMOVE_STATE: assert property (@(posedge clk_i) disable iff (rst_i) // R1
    (top_reg.st == ST_RUN && both_off) |=> (top_reg.st == ST_REMOVED))
    else $error("removal not entered on both channels OFF");

  AST_ONE_RUN: assert property (@(posedge clk_i) disable iff (rst_i) // R16
    (top_reg.st == ST_RUN && one_off) |=> (top_reg.st == ST_RUN && !ready_o))
    else $error("one channel OFF changed state or kept ready");

  AST_NO_CLR_STAY: assert property (@(posedge clk_i) disable iff (rst_i) // R9
    (top_reg.st == ST_WAIT_CLR && !ch.clr_sync) |=> (top_reg.st != ST_RUN))
    else $error("run entered without clear");

  AST_GATE_ON: assert property (@(posedge clk_i) disable iff (rst_i) // R18
    (top_reg.st == ST_RUN && ch.a_on) |=> upper_gate_en_o)
    else $error("upper arm blocked with its channel ON");
endmodule : dpr_power_removal
